/* rtl/csf_defs.svh */
// Constants of the configuration stream front end: offsets, patterns, codes, timings.
// Assumes hclk at 20 MHz; included by the front end, the checker and the bench.
//
// Functional notes
// - Scan instruction register is six bits wide on single-die parts.
// - Instruction 110001 puts the otp_aes_key_select register between scan input and output.
// - Instruction 110011 puts the 32-bit otp_user_word_select word in the scan path.
// - Instruction 110100 puts the fuse control register in the scan path.
// - Fuses are read and programmed over the scan port only.
// - Words are discarded until the sync word AA995566 is seen.
// - Parallel ports first find 000000BB then 11220044, then search sync.
// - After sync each 32-bit word is a packet or packet element.
// - Header 30008001 writes one word to the command register, low five bits.
// - Header 30022001 writes the watchdog timer; zero leaves it unused.
// - Header 30020001 writes the warm boot start address.
// - Command 00000 is a null command without effect.
// - Command 00111 clears the running CRC accumulator.
// - Header 30026001 stores a precomputed readback CRC.
// - Header 30012001 writes the first option register.
// - Header 3001C001 writes the second option register.
// - Header 30018001 writes an identity; mismatch flags an error.
// - Command 01001 switches the config clock to the programmed rate.
// - Stacked parts use instruction codes longer than six bits.
`ifndef CSF_DEFS_SVH
`define CSF_DEFS_SVH

`define CSF_CLK_NS      50
`define CSF_INIT_NS     2000
`define CSF_INIT_CYC    ((`CSF_INIT_NS + `CSF_CLK_NS - 1) / `CSF_CLK_NS)

`define CSF_OFS_CTRL    8'h00
`define CSF_OFS_STATUS  8'h04
`define CSF_OFS_TIMER   8'h08
`define CSF_OFS_WBOOT   8'h0C
`define CSF_OFS_RBCRC   8'h10
`define CSF_OFS_OPT1    8'h14
`define CSF_OFS_OPT2    8'h18
`define CSF_OFS_CRC     8'h1C
`define CSF_OFS_RATE    8'h20
`define CSF_OFS_CMD     8'h24

`define CSF_PAD_WORD    32'hFFFFFFFF
`define CSF_WIDTH_W1    32'h000000BB
`define CSF_WIDTH_W2    32'h11220044
`define CSF_SYNC_WORD   32'hAA995566
`define CSF_HDR_CMD     32'h30008001
`define CSF_HDR_TIMER   32'h30022001
`define CSF_HDR_WBOOT   32'h30020001
`define CSF_HDR_RBCRC   32'h30026001
`define CSF_HDR_OPT1    32'h30012001
`define CSF_HDR_OPT2    32'h3001C001
`define CSF_HDR_ID      32'h30018001

`define CSF_CMD_NULL    5'h00
`define CSF_CMD_CRCRST  5'h07
`define CSF_CMD_SWITCH  5'h09
`define CSF_RATE_LSB    17
`define CSF_RATE_W      6

`define CSF_IR_KEY      6'h31
`define CSF_IR_USER     6'h33
`define CSF_IR_CNTL     6'h34
`define CSF_IR_BYPASS   6'h3F
`define CSF_IR_CAPTURE  6'h01
`define CSF_KEY_LEN     256
`define CSF_USER_LEN    32
`define CSF_CNTL_LEN    14
`define CSF_CNTL_WKU    2
`define CSF_CNTL_RKEY   3
`define CSF_CNTL_RUSER  4
`define CSF_CNTL_WCNTL  5

`endif

/* rtl/csf_pkg.sv */
// Types of the configuration stream front end.
// Needs no constant from csf_defs.svh; its encodings are given here.
package csf_pkg;
  typedef enum logic [15:0] {
    TAP_TLR = 16'h0001, TAP_RTI = 16'h0002, TAP_SDR = 16'h0004, TAP_CDR = 16'h0008,
    TAP_SHD = 16'h0010, TAP_E1D = 16'h0020, TAP_PD  = 16'h0040, TAP_E2D = 16'h0080,
    TAP_UDR = 16'h0100, TAP_SIR = 16'h0200, TAP_CIR = 16'h0400, TAP_SHI = 16'h0800,
    TAP_E1I = 16'h1000, TAP_PI  = 16'h2000, TAP_E2I = 16'h4000, TAP_UIR = 16'h8000
  } csf_tap_t;
  typedef enum logic [4:0] {
    ST_WID1 = 5'h01, ST_WID2 = 5'h02, ST_SYNC = 5'h04, ST_HDR = 5'h08, ST_DATA = 5'h10
  } csf_stream_t;
  typedef enum logic [2:0] {
    TG_CMD, TG_TIMER, TG_WBOOT, TG_RBCRC, TG_OPT1, TG_OPT2, TG_ID
  } csf_tgt_t;
endpackage : csf_pkg

/* rtl/csf_config_front_end.sv */
// Configuration stream front end: serial word stream, packet decode, fuse scan port.
// Assumes an AHB-Lite master on hclk; scan and config pins are asynchronous.
//
// Decided for this implementation: the AHB-Lite slave port and the address map.
`timescale 1ns/100ps
`include "csf_defs.svh"

module csf_config_front_end #(
  parameter logic [31:0] DEVICE_ID = 32'h0C5F0001, // Arbitrary identity value
  parameter int          IR_W      = 6,
  parameter int          INIT_CYC  = `CSF_INIT_CYC
) (
  // Clock and reset
  input  wire logic                 hclk,
  input  wire logic                 hresetn,
  // AHB-Lite slave
  input  wire logic                 hsel,
  input  wire logic [31:0]          haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic [31:0]          hwdata,
  input  wire logic                 hready,
  output logic                      hreadyout,
  output logic [31:0]               hrdata,
  output logic                      hresp,
  // Config stream pins
  input  wire logic                 config_clock,
  input  wire logic                 config_data,
  output logic                      init_done_o,
  output logic                      init_done_oe,
  output logic [`CSF_RATE_W-1:0]    config_clock_rate,
  // Scan port pins
  input  wire logic                 tck,
  input  wire logic                 tms,
  input  wire logic                 tdi,
  output logic                      tdo,
  output logic                      tdo_oe
);
  import csf_pkg::*;

  localparam logic [IR_W-1:0] IR_KEY  = IR_W'(`CSF_IR_KEY);
  localparam logic [IR_W-1:0] IR_USER = IR_W'(`CSF_IR_USER);
  localparam logic [IR_W-1:0] IR_CNTL = IR_W'(`CSF_IR_CNTL);
  localparam logic [IR_W-1:0] IR_BYP  = {IR_W{1'b1}};
  localparam logic [IR_W-1:0] IR_CAP  = IR_W'(`CSF_IR_CAPTURE);
  localparam int KL = `CSF_KEY_LEN;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [4:0] sync1_q;
  logic [4:0] sync2_q;
  logic [1:0] edge_q;
  logic       tck_rise;
  logic       tck_fall;
  logic       config_clock_rise;
  logic       tms_s;
  logic       tdi_s;
  logic       cdata_s;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1_q <= 5'h00;
      sync2_q <= 5'h00;
      edge_q  <= 2'h0;
    end else begin
      sync1_q <= {config_data, config_clock, tdi, tms, tck};
      sync2_q <= sync1_q;
      edge_q  <= {sync2_q[3], sync2_q[0]};
    end
  end

  assign tms_s     = sync2_q[1];
  assign tdi_s     = sync2_q[2];
  assign cdata_s   = sync2_q[4];
  assign tck_rise  = sync2_q[0] & ~edge_q[0];
  assign tck_fall  = ~sync2_q[0] & edge_q[0];
  assign config_clock_rise = sync2_q[3] & ~edge_q[1];

  // ----------------------------------------------------------------
  // Scan state machine
  // ----------------------------------------------------------------
  csf_tap_t tap_q;
  csf_tap_t tap_d;

  always_comb begin
    case (tap_q)
      TAP_TLR: tap_d = tms_s ? TAP_TLR : TAP_RTI;
      TAP_RTI: tap_d = tms_s ? TAP_SDR : TAP_RTI;
      TAP_SDR: tap_d = tms_s ? TAP_SIR : TAP_CDR;
      TAP_CDR: tap_d = tms_s ? TAP_E1D : TAP_SHD;
      TAP_SHD: tap_d = tms_s ? TAP_E1D : TAP_SHD;
      TAP_E1D: tap_d = tms_s ? TAP_UDR : TAP_PD;
      TAP_PD:  tap_d = tms_s ? TAP_E2D : TAP_PD;
      TAP_E2D: tap_d = tms_s ? TAP_UDR : TAP_SHD;
      TAP_UDR: tap_d = tms_s ? TAP_SDR : TAP_RTI;
      TAP_SIR: tap_d = tms_s ? TAP_TLR : TAP_CIR;
      TAP_CIR: tap_d = tms_s ? TAP_E1I : TAP_SHI;
      TAP_SHI: tap_d = tms_s ? TAP_E1I : TAP_SHI;
      TAP_E1I: tap_d = tms_s ? TAP_UIR : TAP_PI;
      TAP_PI:  tap_d = tms_s ? TAP_E2I : TAP_PI;
      TAP_E2I: tap_d = tms_s ? TAP_UIR : TAP_SHI;
      TAP_UIR: tap_d = tms_s ? TAP_SDR : TAP_RTI;
      default: tap_d = TAP_TLR;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tap_q <= TAP_TLR;
    end else if (tck_rise) begin
      tap_q <= tap_d;
    end
  end

  // ----------------------------------------------------------------
  // Instruction register
  // ----------------------------------------------------------------
  logic [IR_W-1:0] ir_sh_q;
  logic [IR_W-1:0] ir_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ir_sh_q <= IR_BYP;
      ir_q    <= IR_BYP;
    end else if (tck_rise) begin
      case (tap_q)
        TAP_TLR: ir_q    <= IR_BYP;
        TAP_CIR: ir_sh_q <= IR_CAP;
        TAP_SHI: ir_sh_q <= {tdi_s, ir_sh_q[IR_W-1:1]};
        TAP_UIR: ir_q    <= ir_sh_q;
        default: ir_q    <= ir_q;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Fuse data registers
  // ----------------------------------------------------------------
  logic [KL-1:0]               key_q;
  logic [`CSF_USER_LEN-1:0]    user_q;
  logic [`CSF_CNTL_LEN-1:0]    cntl_q;
  logic [KL-1:0]               dr_q;
  logic [KL-1:0]               key_rev;
  logic [KL-1:0]               dr_rev;
  logic [7:0]                  dr_top;
  logic                        key_user_locked;

  // Key leaves with its top bit first, so it sits reversed in the chain
  for (genvar i = 0; i < KL; i++) begin : g_rev
    assign key_rev[i] = key_q[KL-1-i];
    assign dr_rev[i]  = dr_q[KL-1-i];
  end

  assign key_user_locked = cntl_q[`CSF_CNTL_WKU] | cntl_q[`CSF_CNTL_RKEY]
                         | cntl_q[`CSF_CNTL_RUSER];

  always_comb begin
    case (ir_q)
      IR_KEY:  dr_top = 8'(KL - 1);
      IR_USER: dr_top = 8'(`CSF_USER_LEN - 1);
      IR_CNTL: dr_top = 8'(`CSF_CNTL_LEN - 1);
      default: dr_top = 8'h00;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dr_q <= '0;
    end else if (tck_rise) begin
      if (tap_q == TAP_CDR) begin
        case (ir_q)
          IR_KEY:  dr_q <= cntl_q[`CSF_CNTL_RKEY] ? '0 : key_rev;
          IR_USER: dr_q <= cntl_q[`CSF_CNTL_RUSER] ? '0 :
                           {{(KL-`CSF_USER_LEN){1'b0}}, user_q};
          IR_CNTL: dr_q <= {{(KL-`CSF_CNTL_LEN){1'b0}}, cntl_q};
          default: dr_q <= '0;
        endcase
      end else if (tap_q == TAP_SHD) begin
        dr_q         <= {1'b0, dr_q[KL-1:1]};
        dr_q[dr_top] <= tdi_s;
      end
    end
  end

  // One-time bits only ever set; locked registers refuse the update
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      key_q  <= '0;
      user_q <= '0;
      cntl_q <= '0;
    end else if (tck_rise && tap_q == TAP_UDR) begin
      case (ir_q)
        IR_KEY:  if (!key_user_locked) key_q <= key_q | dr_rev;
        IR_USER: if (!key_user_locked) user_q <= user_q | dr_q[`CSF_USER_LEN-1:0];
        IR_CNTL: if (!cntl_q[`CSF_CNTL_WCNTL]) cntl_q <= cntl_q | dr_q[`CSF_CNTL_LEN-1:0];
        default: key_q <= key_q;
      endcase
    end
  end

  // Scan output changes on the falling scan clock
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tdo    <= 1'b0;
      tdo_oe <= 1'b0;
    end else if (tck_fall) begin
      tdo    <= (tap_q == TAP_SHI) ? ir_sh_q[0] : dr_q[0];
      tdo_oe <= (tap_q == TAP_SHI) | (tap_q == TAP_SHD);
    end
  end

  // ----------------------------------------------------------------
  // Initialisation and init done pin
  // ----------------------------------------------------------------
  logic [15:0] init_cnt_q;
  logic        init_busy;

  assign init_busy = (init_cnt_q != 16'h0000);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      init_cnt_q   <= 16'(INIT_CYC);
      init_done_o  <= 1'b0;
      init_done_oe <= 1'b1;
    end else begin
      init_done_o  <= 1'b0;
      init_done_oe <= init_busy;
      if (init_busy) begin
        init_cnt_q <= init_cnt_q - 16'h0001;
      end
    end
  end

  // ----------------------------------------------------------------
  // Config stream and packet decode
  // ----------------------------------------------------------------
  csf_stream_t st_q;
  csf_tgt_t    tgt_q;
  logic [31:0] sh_q;
  logic [31:0] wd;
  logic [4:0]  bit_q;
  logic        word_done;
  logic        par_mode_q;
  logic        restart_q;
  logic        width_ok_q;
  logic        id_err_q;
  logic [4:0]  cmd_q;
  logic [31:0] timer_q;
  logic [31:0] wboot_q;
  logic [31:0] rbcrc_q;
  logic [31:0] opt1_q;
  logic [31:0] opt2_q;
  logic [31:0] crc_q;
  logic        cbit;
  logic        sync_hit;

  // Words before release are ignored, the host must wait for it
  assign cbit      = config_clock_rise & ~init_busy;
  assign wd        = {sh_q[30:0], cdata_s};
  assign word_done = cbit & (bit_q == 5'h1F);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sh_q  <= 32'h00000000;
      bit_q <= 5'h00;
    end else if (cbit) begin
      sh_q  <= wd;
      bit_q <= sync_hit ? 5'h00 : bit_q + 5'h01;
    end
  end

  // Search states slide bit by bit; alignment is fixed once a pattern hits
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q       <= ST_SYNC;
      tgt_q      <= TG_CMD;
      width_ok_q <= 1'b0;
    end else if (restart_q) begin
      st_q       <= par_mode_q ? ST_WID1 : ST_SYNC;
      width_ok_q <= 1'b0;
    end else if (cbit) begin
      case (st_q)
        ST_WID1: if (wd == `CSF_WIDTH_W1) st_q <= ST_WID2;
        ST_WID2: if (word_done) begin
          width_ok_q <= (wd == `CSF_WIDTH_W2);
          st_q       <= (wd == `CSF_WIDTH_W2) ? ST_SYNC : ST_WID1;
        end
        ST_SYNC: if (wd == `CSF_SYNC_WORD) st_q <= ST_HDR;
        ST_HDR: if (word_done) begin
          st_q <= ST_DATA;
          case (wd)
            `CSF_HDR_CMD:   tgt_q <= TG_CMD;
            `CSF_HDR_TIMER: tgt_q <= TG_TIMER;
            `CSF_HDR_WBOOT: tgt_q <= TG_WBOOT;
            `CSF_HDR_RBCRC: tgt_q <= TG_RBCRC;
            `CSF_HDR_OPT1:  tgt_q <= TG_OPT1;
            `CSF_HDR_OPT2:  tgt_q <= TG_OPT2;
            `CSF_HDR_ID:    tgt_q <= TG_ID;
            default:        st_q  <= ST_HDR;
          endcase
        end
        ST_DATA: if (word_done) st_q <= ST_HDR;
        default: st_q <= ST_SYNC;
      endcase
    end
  end

  // Sync search realigns the word counter on the match
  assign sync_hit = cbit & (((st_q == ST_SYNC) & (wd == `CSF_SYNC_WORD))
                          | ((st_q == ST_WID1) & (wd == `CSF_WIDTH_W1)));

  logic data_wr;
  assign data_wr = word_done & (st_q == ST_DATA) & ~restart_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cmd_q   <= `CSF_CMD_NULL;
      timer_q <= 32'h00000000;
      wboot_q <= 32'h00000000;
      rbcrc_q <= 32'h00000000;
      opt1_q  <= 32'h00000000;
      opt2_q  <= 32'h00000000;
    end else if (data_wr) begin
      case (tgt_q)
        TG_CMD:   cmd_q   <= wd[4:0];
        TG_TIMER: timer_q <= wd;
        TG_WBOOT: wboot_q <= wd;
        TG_RBCRC: rbcrc_q <= wd;
        TG_OPT1:  opt1_q  <= wd;
        TG_OPT2:  opt2_q  <= wd;
        default:  cmd_q   <= cmd_q;
      endcase
    end
  end

  // A restart in the same cycle blocks the write, so a mismatch there is dropped and the flag clears
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      id_err_q <= 1'b0;
    end else if (data_wr && tgt_q == TG_ID && wd != DEVICE_ID) begin
      id_err_q <= 1'b1;
    end else if (restart_q) begin
      id_err_q <= 1'b0;
    end
  end

  // Simple rotate-xor signature; only words after sync are covered
  logic crc_clear;
  assign crc_clear = data_wr & (tgt_q == TG_CMD) & (wd[4:0] == `CSF_CMD_CRCRST);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      crc_q <= 32'h00000000;
    end else if (crc_clear || restart_q) begin
      crc_q <= 32'h00000000;
    end else if (word_done && (st_q == ST_HDR || st_q == ST_DATA)) begin
      crc_q <= {crc_q[30:0], crc_q[31]} ^ wd;
    end
  end

  // Only the switch command loads the rate; the null command only loads cmd_q and the CRC
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      config_clock_rate <= '0;
    end else if (data_wr && tgt_q == TG_CMD && wd[4:0] == `CSF_CMD_SWITCH) begin
      config_clock_rate <= opt1_q[`CSF_RATE_LSB +: `CSF_RATE_W];
    end
  end

  // ----------------------------------------------------------------
  // AHB-Lite slave
  // ----------------------------------------------------------------
  logic       wr_pend_q;
  logic       rd_pend_q;
  logic [7:0] addr_q;
  logic       take;
  logic [31:0] rd_mux;
  logic [31:0] status;

  assign take   = hsel & htrans[1] & hready;
  assign status = {22'h000000, cmd_q, (timer_q != 32'h00000000),
                   id_err_q, width_ok_q, st_q[3] | st_q[4], par_mode_q};

  always_comb begin
    case (addr_q)
      `CSF_OFS_CTRL:   rd_mux = {31'h00000000, par_mode_q};
      `CSF_OFS_STATUS: rd_mux = status;
      `CSF_OFS_TIMER:  rd_mux = timer_q;
      `CSF_OFS_WBOOT:  rd_mux = wboot_q;
      `CSF_OFS_RBCRC:  rd_mux = rbcrc_q;
      `CSF_OFS_OPT1:   rd_mux = opt1_q;
      `CSF_OFS_OPT2:   rd_mux = opt2_q;
      `CSF_OFS_CRC:    rd_mux = crc_q;
      `CSF_OFS_RATE:   rd_mux = {26'h0000000, config_clock_rate};
      `CSF_OFS_CMD:    rd_mux = {27'h0000000, cmd_q};
      default:         rd_mux = 32'h00000000;
    endcase
  end

  // Reads take one wait state so data reflects any write just before
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      addr_q    <= 8'h00;
      hreadyout <= 1'b1;
      hrdata    <= 32'h00000000;
      hresp     <= 1'b0;
    end else begin
      hresp <= 1'b0;
      if (rd_pend_q) begin
        hrdata    <= rd_mux;
        hreadyout <= 1'b1;
        rd_pend_q <= 1'b0;
      end else if (take) begin
        addr_q    <= (haddr[31:8] == 24'h000000) ? haddr[7:0] : 8'hFF;
        wr_pend_q <= hwrite;
        rd_pend_q <= ~hwrite;
        hreadyout <= hwrite;
      end else begin
        wr_pend_q <= 1'b0;
      end
    end
  end

  // Software can steer the stream but never reaches the fuses
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      par_mode_q <= 1'b0;
      restart_q  <= 1'b0;
    end else begin
      restart_q <= 1'b0;
      if (wr_pend_q && addr_q == `CSF_OFS_CTRL) begin
        par_mode_q <= hwdata[0];
        restart_q  <= hwdata[1];
      end
    end
  end

endmodule : csf_config_front_end

/* verification/csf_front_end_asserts.sv */
// Checker of bus timing and pin behaviour of the front end.
// Bound to csf_config_front_end; sees its ports only.
`timescale 1ns/100ps
`include "csf_defs.svh"
module csf_front_end_asserts #(
  parameter int INIT_CYC = 40
) (
  // Clock and reset
  input wire logic                    hclk,
  input wire logic                    hresetn,
  // Bus
  input wire logic                    hsel,
  input wire logic [1:0]              htrans,
  input wire logic                    hwrite,
  input wire logic                    hready,
  input wire logic                    hreadyout,
  input wire logic [31:0]             hrdata,
  input wire logic                    hresp,
  // Pins
  input wire logic                    tck,
  input wire logic                    init_done_o,
  input wire logic                    init_done_oe,
  input wire logic [`CSF_RATE_W-1:0]  config_clock_rate,
  input wire logic                    tdo_oe
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic [7:0] cnt_q;
  wire        take_rd = hsel && htrans[1] && hready && !hwrite;
  wire        take_wr = hsel && htrans[1] && hready && hwrite;
  // Saturating age since reset release
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) cnt_q <= 8'h00;
    else if (cnt_q != 8'hFF) cnt_q <= cnt_q + 8'h01;
  end
  bus_okay_a: assert property (hresp == 1'b0)
    else $error("hresp not okay");
  write_no_wait_a: assert property (take_wr |=> hreadyout)
    else $error("write inserted a wait");
  read_one_wait_a: assert property (take_rd |=> !hreadyout ##1 hreadyout)
    else $error("read wait not one cycle");
  wait_cause_a: assert property ($fell(hreadyout) |-> $past(take_rd))
    else $error("wait without a read");
  rdata_hold_a: assert property ($changed(hrdata) |-> !$past(hreadyout))
    else $error("read data moved outside a read");
  init_pin_low_a: assert property (init_done_o == 1'b0)
    else $error("init pin driven high");
  init_hold_a: assert property (cnt_q < INIT_CYC - 1 |-> init_done_oe)
    else $error("init released too early");
  rate_quiet_a: assert property ($changed(config_clock_rate) |-> !init_done_oe)
    else $error("rate moved during init");
  scan_oe_edge_a: assert property ($changed(tdo_oe) |-> !tck)
    else $error("scan enable moved with clock high");
  cover property (take_rd);
  cover property ($fell(init_done_oe));
  cover property ($rose(tdo_oe));
endmodule : csf_front_end_asserts

bind csf_config_front_end csf_front_end_asserts #(.INIT_CYC(INIT_CYC)) u_asserts (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
  .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .tck(tck),
  .init_done_o(init_done_o), .init_done_oe(init_done_oe),
  .config_clock_rate(config_clock_rate), .tdo_oe(tdo_oe));

/* verification/csf_host_model.sv */
// Model of the configuration host and the scan controller.
// Timed by delays only; link clock idles low between frames.
`timescale 1ns/100ps
module csf_host_model (
  // Config link
  output logic       config_clock,
  output logic       config_data,
  input  wire logic  init_done_oe,
  // Scan port
  output logic       tck,
  output logic       tms,
  output logic       tdi,
  input  wire logic  tdo
);
  int misses = 0;
  initial begin
    config_clock = 1'b0;
    config_data = 1'b1;
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end
  // Odd offset keeps link edges off the hclk grid
  task automatic send_word(input logic [31:0] w);
    int n;
    n = 0;
    while (init_done_oe !== 1'b0 && n < 400) begin
      #50;
      n++;
    end
    if (n == 400) misses++;
    #13.7;
    for (int i = 31; i >= 0; i--) begin
      config_data = w[i];
      #200 config_clock = 1'b1;
      #200 config_clock = 1'b0;
    end
    config_data = ~w[0];
  endtask : send_word
  task automatic step(input logic m, input logic d, output logic o);
    tms = m;
    tdi = d;
    #200 o = tdo;
    tck = 1'b1;
    #200 tck = 1'b0;
  endtask : step
  task automatic tap_reset;
    logic o;
    repeat (5) step(1'b1, 1'b0, o);
    step(1'b0, 1'b0, o);
  endtask : tap_reset
  // Scan from idle and back; bit 0 of din goes first
  task automatic scan(input logic ir, input int n, input logic [255:0] din,
                      output logic [255:0] dout);
    logic o;
    dout = 256'h0;
    #13.7;
    step(1'b1, 1'b0, o);
    if (ir) step(1'b1, 1'b0, o);
    step(1'b0, 1'b0, o);
    step(1'b0, 1'b0, o);
    for (int k = 0; k < n; k++) begin
      step(k == n - 1, din[k], o);
      dout[k] = o;
    end
    step(1'b1, 1'b0, o);
    step(1'b0, 1'b0, o);
    tdi = ~din[n-1];
  endtask : scan
endmodule : csf_host_model

/* verification/config_stream_front_end_tb_top.sv */
// Self-checking bench of the configuration stream front end.
// Bus driven at hclk edges; link and scan pins come from the host model.
`timescale 1ns/100ps
`include "csf_defs.svh"
module config_stream_front_end_tb_top;
  localparam logic [31:0] ID = 32'h5A5A0C01; // Arbitrary identity value
  logic         hclk = 1'b0;
  logic         hresetn = 1'b0;
  logic         hsel = 1'b0;
  logic [31:0]  haddr = 32'h0;
  logic [1:0]   htrans = 2'h0;
  logic         hwrite = 1'b0;
  logic [2:0]   hsize = 3'h2;
  logic [31:0]  hwdata = 32'h0;
  logic [31:0]  v, x, opt;
  logic [255:0] sv, so;
  logic [31:0]  hdrs [5] = '{`CSF_HDR_TIMER, `CSF_HDR_WBOOT, `CSF_HDR_RBCRC,
                             `CSF_HDR_OPT1, `CSF_HDR_OPT2};
  logic [31:0]  ofs [5] = '{`CSF_OFS_TIMER, `CSF_OFS_WBOOT, `CSF_OFS_RBCRC,
                            `CSF_OFS_OPT1, `CSF_OFS_OPT2};
  wire          hreadyout, hresp, init_done_o, init_done_oe, tdo, tdo_oe;
  wire          config_clock, config_data, tck, tms, tdi;
  wire [31:0]   hrdata;
  wire [5:0]    rate;
  int           fails = 0, tests_run = 0;
  always #25 hclk = ~hclk;
  csf_config_front_end #(.DEVICE_ID(ID), .IR_W(6), .INIT_CYC(4)) u_csf_config_front_end (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .config_clock(config_clock),
    .config_data(config_data), .init_done_o(init_done_o), .init_done_oe(init_done_oe),
    .config_clock_rate(rate), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe));
  csf_host_model u_csf_host_model (
    .config_clock(config_clock), .config_data(config_data), .init_done_oe(init_done_oe),
    .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));
  task automatic conclude;
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : conclude
  task automatic chk(input string nm, input logic [255:0] e, input logic [255:0] g);
    tests_run++;
    if (g !== e) begin
      fails++;
      $display("wrong value %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  task automatic hwait;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 20);
    if (hreadyout !== 1'b1) begin
      fails++;
      conclude();
    end
  endtask : hwait
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    hwait();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    hwait();
    v = hrdata;
  endtask : ahb
  task automatic rd(input string nm, input logic [31:0] a, e, m);
    ahb(1'b0, a, 32'h0);
    chk(nm, e, v & m);
  endtask : rd
  // Effects land a few hclk after the last bit
  task automatic pkt(input logic [31:0] h, input logic [31:0] d);
    u_csf_host_model.send_word(h);
    u_csf_host_model.send_word(d);
    repeat (8) @(posedge hclk);
  endtask : pkt
  task automatic dr(input logic [5:0] c, input int n, input logic [255:0] d);
    u_csf_host_model.scan(1'b1, 6, {250'h0, c}, so);
    chk("ir capture", 256'h1, so[5:0]);
    u_csf_host_model.scan(1'b0, n, d, so);
  endtask : dr
  initial begin
    repeat (40000) @(posedge hclk);
    fails++;
    conclude();
  end
  initial begin
    x = $urandom(71);
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    ahb(1'b1, `CSF_OFS_CTRL, 32'h3);
    pkt(`CSF_PAD_WORD, `CSF_SYNC_WORD);
    rd("sync before width", `CSF_OFS_STATUS, 32'h1, 32'h7);
    pkt(`CSF_WIDTH_W1, `CSF_WIDTH_W2);
    rd("width found", `CSF_OFS_STATUS, 32'h5, 32'h7);
    pkt(`CSF_PAD_WORD, `CSF_SYNC_WORD);
    rd("parallel synced", `CSF_OFS_STATUS, 32'h7, 32'h7);
    $display("parallel test done");
    ahb(1'b1, `CSF_OFS_CTRL, 32'h2);
    pkt(`CSF_HDR_TIMER, $urandom() | 32'h1);
    rd("unsynced", `CSF_OFS_STATUS, 32'h0, 32'h3);
    rd("timer kept", `CSF_OFS_TIMER, 32'h0, 32'hFFFFFFFF);
    pkt(`CSF_PAD_WORD, `CSF_SYNC_WORD);
    rd("synced", `CSF_OFS_STATUS, 32'h2, 32'h3);
    for (int i = 0; i < 5; i++) begin
      x = $urandom() | 32'h1;
      if (i == 3) opt = x;
      pkt(hdrs[i], x);
      rd("stream reg", ofs[i], x, 32'hFFFFFFFF);
    end
    rd("watchdog on", `CSF_OFS_STATUS, 32'h10, 32'h10);
    pkt(`CSF_HDR_TIMER, 32'h0);
    rd("watchdog off", `CSF_OFS_STATUS, 32'h0, 32'h10);
    pkt(`CSF_HDR_ID, ID);
    rd("id match", `CSF_OFS_STATUS, 32'h0, 32'h8);
    pkt(`CSF_HDR_ID, ID ^ 32'h100);
    rd("id mismatch", `CSF_OFS_STATUS, 32'h8, 32'h8);
    pkt(`CSF_HDR_CMD, 32'h0);
    rd("null rate", `CSF_OFS_RATE, 32'h0, 32'h3F);
    pkt(`CSF_HDR_CMD, 32'hFFFFFFE7);
    rd("crc cleared", `CSF_OFS_CRC, 32'h0, 32'hFFFFFFFF);
    rd("cmd field", `CSF_OFS_STATUS, 32'hE0, 32'h3E0);
    pkt(`CSF_HDR_CMD, 32'h9);
    rd("switched rate", `CSF_OFS_RATE, {26'h0, opt[22:17]}, 32'h3F);
    chk("rate pin", {250'h0, opt[22:17]}, {250'h0, rate});
    ahb(1'b1, `CSF_OFS_TIMER, 32'h5);
    rd("read only", `CSF_OFS_TIMER, 32'h0, 32'hFFFFFFFF);
    ahb(1'b1, 32'h28, 32'hFFFFFFFF);
    rd("unmapped", 32'h28, 32'h0, 32'hFFFFFFFF);
    $display("stream test done");
    u_csf_host_model.tap_reset();
    for (int i = 0; i < 8; i++) sv = {sv[223:0], $urandom()};
    x = $urandom();
    dr(`CSF_IR_USER, 32, {224'h0, x});
    chk("user blank", 256'h0, so[31:0]);
    dr(`CSF_IR_USER, 32, 256'h0);
    chk("user word", {224'h0, x}, so[31:0]);
    dr(`CSF_IR_KEY, 256, sv);
    chk("key blank", 256'h0, so);
    dr(`CSF_IR_KEY, 256, 256'h0);
    chk("key", sv, so);
    dr(`CSF_IR_CNTL, 14, 256'h10);
    dr(`CSF_IR_CNTL, 14, 256'h0);
    chk("control", 256'h10, so[13:0]);
    dr(`CSF_IR_USER, 32, 256'h0);
    chk("user hidden", 256'h0, so[31:0]);
    $display("scan test done");
    fails += u_csf_host_model.misses;
    conclude();
  end
endmodule : config_stream_front_end_tb_top
